// file: design/pbr_pkg.sv
package pbr_pkg;

   // Timing figures, and the clock rates they are converted with.
   localparam int unsigned DELAY_TIME_MS  = 64;       // Nominal power-up delay.
   localparam int unsigned LF_CLK_HZ      = 31000;    // Internal low-frequency clock rate.
   localparam int unsigned SYS_CLK_MHZ    = 250;      // Rate of sys_clk.
   localparam int unsigned BRN_FILT_NS    = 1000;     // Brown-out noise filter duration.

   // Delay ticks of the low-frequency clock, and filter length in sys_clk cycles (rounded up).
   localparam int unsigned DELAY_TICKS    = DELAY_TIME_MS * LF_CLK_HZ / 1000;
   localparam int unsigned BRN_FILT_CYC   = (BRN_FILT_NS * SYS_CLK_MHZ + 999) / 1000;

   // Brown-out operating modes, as coded in the two-bit mode field.
   typedef enum logic [1:0] {
      PBR_MODE_OFF       = 2'h0,
      PBR_MODE_SW        = 2'h1,
      PBR_MODE_SLEEP_OFF = 2'h2,
      PBR_MODE_ON        = 2'h3
   } pbr_mode_t;

   // Start-up sequence states, one-hot.
   typedef enum logic [3:0] {
      PBR_ST_HOLD = 4'h1,
      PBR_ST_TMR  = 4'h2,
      PBR_ST_WAIT = 4'h4,
      PBR_ST_RUN  = 4'h8
   } pbr_state_t;

   // Register map, byte addresses.
   localparam logic [7:0]  PBR_CTRL_OFS   = 8'h00;
   localparam logic [7:0]  PBR_STAT_OFS   = 8'h04;

   // Control register fields and reset values.
   localparam int unsigned CTRL_SWEN_BIT  = 7;
   localparam int unsigned CTRL_FAST_BIT  = 6;
   localparam int unsigned CTRL_RDY_BIT   = 0;
   localparam logic        CTRL_SWEN_RST  = 1'b1;
   localparam logic        CTRL_FAST_RST  = 1'b0;

   // Status register fields.
   localparam int unsigned STAT_POR_BIT   = 0;
   localparam int unsigned STAT_BRN_BIT   = 1;
   localparam int unsigned STAT_TMR_BIT   = 2;
   localparam int unsigned STAT_CLR_BIT   = 3;
   localparam int unsigned STAT_RST_BIT   = 4;

   // Bus responses.
   localparam logic [1:0]  AXI_OKAY       = 2'h0;
   localparam logic [1:0]  AXI_SLVERR     = 2'h2;

   // AXI4-Lite request, from the master.
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } pbr_axil_req_t;

   // AXI4-Lite response, to the master.
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } pbr_axil_rsp_t;

endpackage : pbr_pkg

// file: design/pbr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pbr_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             sys_clk,   // System clock.
   input  wire logic             rst,       // Synchronous reset, active high.
   input  wire logic [WIDTH-1:0] async_in,  // Levels from outside the clock domain.
   output logic      [WIDTH-1:0] sync_out   // Same levels, two flops later.
);

   logic [WIDTH-1:0] meta_q;

   // Two-flop synchroniser; the first stage feeds only the second.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule : pbr_sync

`default_nettype wire

// file: design/pbr_sequencer.sv
// Behaviour
// R1: Core stays in reset while the power-on detector reports low supply.
// R2: Power-up delay times out nominally 64 ms after power-on or brown-out reset.
// R3: Core stays in reset while the enabled power-up delay is still counting.
// R4: Power-up delay enable is active low; a 1 bypasses the delay.
// R5: Power-up delay starts only after power-on and brown-out sources release.
// R6: Delay, brown-out detector or external clear pin each extend start-up reset.
// R7: An active detector resets the core when supply drops to the threshold.
// R8: Two-bit mode field selects always on, off in sleep, software, always off.
// R9: One configuration bit selects the brown-out trip level.
// R10: Brown-out reset only after the dip outlasts the filter time.
// R11: Mode 11 keeps detector active always; execution waits for detector ready.
// R12: Mode 10 detector off in sleep; start-up and wake-up wait for ready.
// R13: Mode 01 software bit enables detector; start-up does not wait.
// R14: Read-only ready bit shows 1 when detector active, 0 when inactive; the code also needs rdy_s, so the bit reads 0 while the detector settles.
// R15: Core reset is the OR of all sources, released on a clock edge.
// R16: Power-up delay counts ticks of the internal low-frequency clock.
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module pbr_sequencer
   import pbr_pkg::*;
#(
   parameter int unsigned DELAY_CNT = DELAY_TICKS,  // Low-frequency ticks of the delay.
   parameter int unsigned FILT_CNT  = BRN_FILT_CYC  // sys_clk cycles of the dip filter.
) (
   input  wire logic          sys_clk,                // System clock.
   input  wire logic          rst,                    // Synchronous reset, active high.
   input  wire logic          lf_clk,                 // Internal low-frequency clock.
   input  wire logic          power_on_detect,        // High while supply below minimum.
   input  wire logic          brownout_below,         // High while supply below threshold.
   input  wire logic          brownout_circuit_rdy,   // High once the detector is settled.
   input  wire logic          external_clear_pin_n,   // External clear, active low.
   input  wire logic          sleep_mode,             // Core is asleep.
   input  wire logic          power_up_delay_enable_n, // Delay enable, active low.
   input  wire logic [1:0]    brownout_mode_select,   // Detector operating mode.
   input  wire logic          brownout_level_select,  // Trip level choice.
   input  wire pbr_axil_req_t axil_req,               // Register bus request.
   output pbr_axil_rsp_t      axil_rsp,               // Register bus response.
   output logic               core_reset,             // Core reset, active high.
   output logic               exec_wait,              // Hold execution after wake-up.
   output logic               brownout_enable,        // Powers the detector.
   output logic               brownout_threshold,     // Trip level to the comparator.
   output logic               bandgap_force           // Keep band gap on always.
);

   localparam int FCNT = FILT_CNT;

   // Cross the analog and pin levels into the clock domain.
   logic [4:0] sync_s;
   logic       lf_s, clear_n_s, rdy_s, below_s, por_s;

   pbr_sync #(.WIDTH(5)) u_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .async_in ({lf_clk, external_clear_pin_n, brownout_circuit_rdy,
                  brownout_below, power_on_detect}),
      .sync_out (sync_s)
   );

   assign {lf_s, clear_n_s, rdy_s, below_s, por_s} = sync_s;

   // Configuration bits are static fuses on the same clock.
   pbr_mode_t  mode;
   assign mode = pbr_mode_t'(brownout_mode_select);

   logic       sw_en_q, fast_q;
   logic       det_active, ready_bit, mode_waits, brn_rst;

   // Detector activity for each mode.
   always_comb begin
      unique case (mode)
         PBR_MODE_ON:        det_active = 1'b1;         // R11
         PBR_MODE_SLEEP_OFF: det_active = ~sleep_mode;  // R12
         PBR_MODE_SW:        det_active = sw_en_q;      // R13
         PBR_MODE_OFF:       det_active = 1'b0;         // R8
      endcase
   end

   // The detector only protects once it is settled, which matters in software mode.
   assign ready_bit     = det_active & rdy_s;                                  // R14
   assign mode_waits    = (mode == PBR_MODE_ON) || (mode == PBR_MODE_SLEEP_OFF); // R11 R12
   assign brownout_enable    = det_active;
   assign brownout_threshold = brownout_level_select;                           // R9
   assign bandgap_force = fast_q & ((mode == PBR_MODE_SW) || (mode == PBR_MODE_SLEEP_OFF));

   // Dip filter: the count restarts on any recovery, so short dips are ignored.
   logic [15:0] filt_cnt_q;
   logic        dip;
   assign dip = ready_bit & below_s;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         filt_cnt_q <= '0;
      end else if (!dip) begin
         filt_cnt_q <= '0;                                       // R10
      end else if (filt_cnt_q != 16'(FILT_CNT)) begin
         filt_cnt_q <= filt_cnt_q + 16'h0001;
      end
   end

   // Brown-out reset stands until the supply recovers or the detector turns off.
   assign brn_rst = dip && (filt_cnt_q == 16'(FILT_CNT));        // R7 R10

   // Rising edges of the low-frequency clock drive the delay counter.
   logic lf_prev_q, lf_tick;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lf_prev_q <= 1'b0;
      end else begin
         lf_prev_q <= lf_s;
      end
   end

   assign lf_tick = lf_s & ~lf_prev_q;                           // R16

   // Start-up sequence: hold, power-up delay, ready wait, run.
   pbr_state_t  state_q;
   logic [15:0] tick_cnt_q;
   logic        src_hold;

   assign src_hold = por_s | brn_rst;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= PBR_ST_HOLD;
      end else if (src_hold) begin
         state_q <= PBR_ST_HOLD;                                 // R1 R7
      end else begin
         unique case (state_q)
            PBR_ST_HOLD: begin
               if (!power_up_delay_enable_n) begin
                  state_q <= PBR_ST_TMR;                         // R4 R5
               end else begin
                  state_q <= PBR_ST_WAIT;                        // R4
               end
            end
            PBR_ST_TMR: begin
               if (lf_tick && tick_cnt_q == 16'(DELAY_CNT - 1)) begin
                  state_q <= PBR_ST_WAIT;                        // R2
               end
            end
            PBR_ST_WAIT: begin
               if (!mode_waits || rdy_s) begin
                  state_q <= PBR_ST_RUN;                         // R11 R12 R13
               end
            end
            PBR_ST_RUN: begin
               state_q <= PBR_ST_RUN;
            end
            default: begin
               state_q <= PBR_ST_HOLD;
            end
         endcase
      end
   end

   // Delay counter runs only in the delay state and restarts on every entry.
   always_ff @(posedge sys_clk) begin
      if (rst || state_q != PBR_ST_TMR) begin
         tick_cnt_q <= '0;
      end else if (lf_tick) begin
         tick_cnt_q <= tick_cnt_q + 16'h0001;                    // R16
      end
   end

   // Core reset is registered so it releases on a clean edge.
   logic core_reset_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         core_reset_q <= 1'b1;
      end else begin
         core_reset_q <= src_hold | ~clear_n_s | (state_q != PBR_ST_RUN); // R3 R6 R15
      end
   end

   assign core_reset = core_reset_q;

   // After wake-up the core keeps running reset-free but must not fetch yet.
   assign exec_wait = (state_q == PBR_ST_RUN) & mode_waits & det_active & ~rdy_s; // R11 R12

   // Register bus: write address and data are held until both have arrived.
   logic        aw_q, w_q, bvalid_q, rvalid_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0]  wstrb_q;
   logic [1:0]  bresp_q, rresp_q;
   logic        take_aw, take_w, take_ar, commit;

   assign take_aw = axil_req.awvalid & ~aw_q;
   assign take_w  = axil_req.wvalid & ~w_q;
   assign take_ar = axil_req.arvalid & ~rvalid_q;
   assign commit  = aw_q & w_q & ~bvalid_q;

   // Capture of the write address and data channels.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         aw_q     <= 1'b0;
         w_q      <= 1'b0;
         awaddr_q <= '0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end else begin
         if (take_aw) begin
            aw_q     <= 1'b1;
            awaddr_q <= axil_req.awaddr;
         end else if (commit) begin
            aw_q <= 1'b0;
         end
         if (take_w) begin
            w_q     <= 1'b1;
            wdata_q <= axil_req.wdata;
            wstrb_q <= axil_req.wstrb;
         end else if (commit) begin
            w_q <= 1'b0;
         end
      end
   end

   // Write response and control register update.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= AXI_OKAY;
         sw_en_q  <= CTRL_SWEN_RST;
         fast_q   <= CTRL_FAST_RST;
      end else begin
         if (commit) begin
            bvalid_q <= 1'b1;
            bresp_q  <= AXI_OKAY;
            if (awaddr_q == PBR_CTRL_OFS) begin
               if (wstrb_q[0]) begin
                  sw_en_q <= wdata_q[CTRL_SWEN_BIT];             // R13
                  fast_q  <= wdata_q[CTRL_FAST_BIT];
               end
            end else if (awaddr_q != PBR_STAT_OFS) begin
               bresp_q <= AXI_SLVERR;
            end
         end else if (axil_req.bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Read channel; the ready bit is sampled live at the address handshake.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= AXI_OKAY;
      end else if (take_ar) begin
         rvalid_q <= 1'b1;
         rdata_q  <= '0;
         rresp_q  <= AXI_OKAY;
         if (axil_req.araddr == PBR_CTRL_OFS) begin
            rdata_q[CTRL_SWEN_BIT] <= sw_en_q;
            rdata_q[CTRL_FAST_BIT] <= fast_q;
            rdata_q[CTRL_RDY_BIT]  <= ready_bit;                 // R14
         end else if (axil_req.araddr == PBR_STAT_OFS) begin
            rdata_q[STAT_POR_BIT]  <= por_s;
            rdata_q[STAT_BRN_BIT]  <= brn_rst;
            rdata_q[STAT_TMR_BIT]  <= (state_q == PBR_ST_TMR);
            rdata_q[STAT_CLR_BIT]  <= ~clear_n_s;
            rdata_q[STAT_RST_BIT]  <= core_reset_q;
         end else begin
            rresp_q <= AXI_SLVERR;
         end
      end else if (axil_req.rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Response bundle back to the master.
   always_comb begin
      axil_rsp.awready = ~aw_q;
      axil_rsp.wready  = ~w_q;
      axil_rsp.bvalid  = bvalid_q;
      axil_rsp.bresp   = bresp_q;
      axil_rsp.arready = ~rvalid_q;
      axil_rsp.rvalid  = rvalid_q;
      axil_rsp.rdata   = rdata_q;
      axil_rsp.rresp   = rresp_q;
   end

   // Checks on the sequencing, all in the sys_clk domain.
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   property p_por_hold;
      por_s |=> core_reset_q ##1 core_reset_q;
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("Reset not held on low supply."); // R1

   property p_tmr_len;
      (state_q == PBR_ST_TMR && lf_tick && tick_cnt_q == 16'(DELAY_CNT - 1) && !src_hold)
         |=> state_q == PBR_ST_WAIT;
   endproperty
   a_tmr_len: assert property (p_tmr_len) else $error("Delay did not end at terminal count."); // R2

   property p_tmr_hold;
      state_q == PBR_ST_TMR |=> core_reset_q;
   endproperty
   a_tmr_hold: assert property (p_tmr_hold) else $error("Core left reset during delay."); // R3

   property p_bypass;
      (state_q == PBR_ST_HOLD && !src_hold && power_up_delay_enable_n)
         |=> state_q == PBR_ST_WAIT;
   endproperty
   a_bypass: assert property (p_bypass) else $error("Disabled delay was not bypassed."); // R4

   property p_tmr_start;
      $rose(state_q == PBR_ST_TMR) |-> $past(!src_hold) && tick_cnt_q == 16'h0000;
   endproperty
   a_tmr_start: assert property (p_tmr_start) else $error("Delay began before release."); // R5

   property p_clear_hold;
      !clear_n_s |=> core_reset_q;
   endproperty
   a_clear_hold: assert property (p_clear_hold) else $error("Clear pin did not hold reset."); // R6

   property p_trip;
      (dip && filt_cnt_q == 16'(FILT_CNT - 1)) ##1 dip |-> brn_rst ##1 core_reset_q;
   endproperty
   a_trip: assert property (p_trip) else $error("Brown-out did not trip after filter."); // R7

   property p_mode_off;
      mode == PBR_MODE_OFF |-> !det_active && !brn_rst;
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("Detector active in off mode."); // R8

   property p_level;
      brownout_threshold == brownout_level_select;
   endproperty
   a_level: assert property (p_level) else $error("Trip level not forwarded."); // R9

   property p_filter;
      $rose(brn_rst) |-> $past(dip) && $past(filt_cnt_q) == 16'(FCNT - 1);
   endproperty
   a_filter: assert property (p_filter) else $error("Brown-out tripped on a short dip."); // R10

   property p_mode_on_wait;
      (state_q == PBR_ST_WAIT && mode == PBR_MODE_ON && !rdy_s) |=> state_q != PBR_ST_RUN;
   endproperty
   a_mode_on_wait: assert property (p_mode_on_wait) else $error("Start-up did not wait."); // R11

   property p_sleep_off;
      (mode == PBR_MODE_SLEEP_OFF && sleep_mode) |-> !brownout_enable;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("Detector on during sleep."); // R12

   property p_sw_mode;
      (state_q == PBR_ST_WAIT && mode == PBR_MODE_SW && !src_hold) |=> state_q == PBR_ST_RUN;
   endproperty
   a_sw_mode: assert property (p_sw_mode) else $error("Software mode start-up waited."); // R13

   property p_ready_read;
      take_ar && axil_req.araddr == PBR_CTRL_OFS |=> rdata_q[CTRL_RDY_BIT] == $past(ready_bit);
   endproperty
   a_ready_read: assert property (p_ready_read) else $error("Ready bit read wrong."); // R14

   property p_release;
      $fell(core_reset_q) |-> $past(!por_s && !brn_rst && clear_n_s && state_q == PBR_ST_RUN);
   endproperty
   a_release: assert property (p_release) else $error("Reset released with a source active."); // R15

   property p_tick_only;
      (state_q == PBR_ST_TMR && !lf_tick) |=> $stable(tick_cnt_q) || state_q != PBR_ST_TMR;
   endproperty
   a_tick_only: assert property (p_tick_only) else $error("Delay counted without a tick."); // R16

endmodule : pbr_sequencer

`default_nettype wire

// file: dv/pbr_supply_model.sv
`timescale 1ns/1ps
`default_nettype none

module pbr_supply_model (
   input  wire logic        sys_clk,              // System clock.
   input  wire logic        det_en,               // Detector powered by the design.
   input  wire logic        vdd_low,              // Supply below minimum.
   input  wire logic        dip,                  // Supply below trip level.
   input  wire logic        clr,                  // Clear pin pressed.
   input  wire logic [15:0] settle,               // Detector settle time in cycles.
   output logic             lf_clk,               // Free-running low-frequency clock.
   output logic             power_on_detect,      // Power-on detector output.
   output logic             brownout_below,       // Comparator output.
   output logic             brownout_circuit_rdy, // Detector settled.
   output logic             external_clear_pin_n  // Clear pin level.
);
   logic [15:0] cnt_q = 16'h0;   // Starts known so the ready output never goes unknown.
   logic        tog_q;

   // The oscillator is always available, so it runs free; 40 ns keeps the run short.
   initial lf_clk = 1'b0;
   always #20 lf_clk = ~lf_clk;

   // Settling restarts each time the detector loses power.
   initial tog_q = 1'b0;
   always @(posedge sys_clk) begin
      tog_q <= ~tog_q;
      if (!det_en) cnt_q <= 16'h0;
      else if (cnt_q < settle) cnt_q <= cnt_q + 16'h1;
   end

   // An unsettled comparator gives no meaningful level, so it toggles every cycle.
   assign brownout_circuit_rdy = det_en && (cnt_q >= settle);
   assign brownout_below       = brownout_circuit_rdy ? dip : tog_q;
   assign power_on_detect      = vdd_low;
   assign external_clear_pin_n = ~clr;
endmodule : pbr_supply_model

`default_nettype wire

// file: dv/power_up_brownout_reset_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none

module power_up_brownout_reset_sequencer_test;
   import pbr_pkg::*;
   localparam int PW = 4;   // Delay ticks.
   localparam int FC = 5;   // Filter cycles.
   localparam int LF = 10;  // sys_clk cycles per low-frequency tick.
   logic sys_clk = 1'b0, rst = 1'b1, sleep_mode = 1'b0, en_n = 1'b0, lvl = 1'b0;
   logic vdd_low = 1'b1, dip = 1'b0, clr = 1'b0;
   logic [1:0] mode = 2'h1;
   logic [15:0] settle = 16'h8;
   pbr_axil_req_t req = '0;
   pbr_axil_rsp_t rsp;
   logic core_reset, exec_wait, bo_en, bo_thr, bg;
   wire logic lf_clk, por, below, rdy, clr_n;
   int fail_count = 0, num_checks = 0, n;
   logic [31:0] q;
   logic [1:0] r;
   time t0;

   // Clock at 250 MHz.
   always #2 sys_clk = ~sys_clk;

   pbr_sequencer #(.DELAY_CNT(PW), .FILT_CNT(FC)) pbr_sequencer_i (
      .sys_clk(sys_clk), .rst(rst), .lf_clk(lf_clk), .power_on_detect(por),
      .brownout_below(below), .brownout_circuit_rdy(rdy), .external_clear_pin_n(clr_n),
      .sleep_mode(sleep_mode), .power_up_delay_enable_n(en_n),
      .brownout_mode_select(mode), .brownout_level_select(lvl), .axil_req(req),
      .axil_rsp(rsp), .core_reset(core_reset), .exec_wait(exec_wait),
      .brownout_enable(bo_en), .brownout_threshold(bo_thr), .bandgap_force(bg));

   pbr_supply_model pbr_supply_model_i (
      .sys_clk(sys_clk), .det_en(bo_en), .vdd_low(vdd_low), .dip(dip), .clr(clr),
      .settle(settle), .lf_clk(lf_clk), .power_on_detect(por), .brownout_below(below),
      .brownout_circuit_rdy(rdy), .external_clear_pin_n(clr_n));

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask : chk

   // Ready and valid are sampled mid-cycle, where they equal what the next edge sees.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      logic aw, w, ar, done;
      pbr_axil_rsp_t s;
      @(posedge sys_clk);
      if (wr) begin
         req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
         req.wdata <= d; req.wstrb <= 4'hf; req.bready <= 1'b1;
      end else begin
         req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
      end
      aw = wr; w = wr; ar = !wr; done = 1'b0;
      for (i = 0; i < 50 && !done; i++) begin
         @(negedge sys_clk) s = rsp;
         @(posedge sys_clk);
         if (aw && s.awready) begin aw = 1'b0; req.awvalid <= 1'b0; end
         if (w && s.wready) begin w = 1'b0; req.wvalid <= 1'b0; end
         if (ar && s.arready) begin ar = 1'b0; req.arvalid <= 1'b0; end
         if (wr && !aw && !w && s.bvalid) begin done = 1'b1; r = s.bresp; req.bready <= 1'b0; end
         if (!wr && !ar && s.rvalid) begin
            done = 1'b1; r = s.rresp; q = s.rdata; req.rready <= 1'b0;
         end
      end
      if (!done) begin fail_count++; complete_run; end
   endtask : bus

   task automatic do_reset(input logic [1:0] m, input logic e);
      @(posedge sys_clk) rst <= 1'b1;
      mode <= m;
      en_n <= e;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      t0 = $time;
   endtask : do_reset

   // Cycles from t0 until the core leaves reset.
   task automatic rel(input int lim);
      int i;
      for (i = 0; i < lim && core_reset !== 1'b0; i++) @(negedge sys_clk);
      if (core_reset !== 1'b0) begin fail_count++; complete_run; end
      n = int'(($time - t0) / 4);
   endtask : rel

   initial begin
      do_reset(2'h1, 1'b0);
      repeat (10) @(posedge sys_clk);
      bus(1'b0, PBR_STAT_OFS, 32'h0); chk(q, 32'h11);
      t0 = $time;
      vdd_low <= 1'b0;
      repeat (15) @(posedge sys_clk);
      bus(1'b0, PBR_STAT_OFS, 32'h0); chk(q, 32'h14);
      bus(1'b0, PBR_CTRL_OFS, 32'h0); chk(q, 32'h81);
      rel(300); chk(32'(n >= (PW - 1) * LF && n <= PW * LF + 20), 32'h1);
      bus(1'b0, 8'h08, 32'h0); chk(q, 32'h0); chk(32'(r), 32'(AXI_SLVERR));
      bus(1'b1, PBR_STAT_OFS, 32'hff); chk(32'(r), 32'(AXI_OKAY));
      bus(1'b1, PBR_CTRL_OFS, 32'h40); chk({30'h0, bo_en, bg}, 32'h1);
      bus(1'b0, PBR_CTRL_OFS, 32'h0); chk(q, 32'h40);
      bus(1'b1, PBR_CTRL_OFS, 32'h80);
      repeat (20) @(posedge sys_clk);
      // A dip as long as the filter must pass unseen.
      dip <= 1'b1;
      repeat (FC) @(posedge sys_clk);
      dip <= 1'b0;
      repeat (20) @(posedge sys_clk);
      chk(32'(core_reset), 32'h0);
      dip <= 1'b1;
      repeat (FC + 10) @(posedge sys_clk);
      chk(32'(core_reset), 32'h1);
      dip <= 1'b0;
      t0 = $time;
      rel(300); chk(32'(n >= (PW - 1) * LF && n <= PW * LF + 20), 32'h1);
      clr <= 1'b1;
      repeat (8) @(posedge sys_clk);
      bus(1'b0, PBR_STAT_OFS, 32'h0); chk(q, 32'h18);
      clr <= 1'b0;
      t0 = $time;
      rel(300); chk(32'(n >= 3 && n <= 4), 32'h1);
      for (int l = 0; l < 2; l++) begin
         @(posedge sys_clk) lvl <= l[0];
         @(negedge sys_clk) chk(32'(bo_thr), 32'(l));
      end
      do_reset(2'h1, 1'b1);
      rel(300); chk(32'(n <= 12), 32'h1);
      settle <= 16'h64;
      do_reset(2'h3, 1'b1);
      // The detector is still settling, so the core must stay held until it reports ready.
      for (n = 0; n < 200 && rdy !== 1'b1; n++) @(negedge sys_clk);
      chk(32'(core_reset), 32'h1);
      t0 = $time;
      rel(20); chk(32'(n >= 3 && n <= 5), 32'h1);
      settle <= 16'h8;
      do_reset(2'h2, 1'b1);
      rel(300);
      @(posedge sys_clk) sleep_mode <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk(32'(bo_en), 32'h0);
      sleep_mode <= 1'b0;
      repeat (5) @(posedge sys_clk);
      chk(32'(exec_wait), 32'h1);
      repeat (20) @(posedge sys_clk);
      chk(32'(exec_wait), 32'h0);
      // Every mode, awake, with the software enable at its reset value.
      for (int m = 0; m < 4; m++) begin
         do_reset(m[1:0], 1'b1);
         repeat (20) @(posedge sys_clk);
         chk(32'(bo_en), 32'(m != 0));
         bus(1'b0, PBR_CTRL_OFS, 32'h0); chk(q, 32'h80 | 32'(m != 0));
      end
      complete_run;
   end
endmodule : power_up_brownout_reset_sequencer_test

`default_nettype wire
